// ===== hw/eeprom_pkg.sv
// How it works
// - Selected only when all three chip-select pins match the control byte bits.
// - Data line is open-drain: pulled low or released, used both ways.
// - Transmitter changes data only while clock is low; high-clock changes are START/STOP.
// - Serial clock is only an input and times every bit.
// - Unconnected write-guard pin reads low through the board pull-down.
// - Guard low allows reads and writes over the whole array.
// - Guard high blocks every array write; reads are unaffected.
// - Programming cycle ends within five milliseconds of its start.
// - Pulses on clock or data no longer than the glitch width are ignored.
// - When transmitting, data holds at least 300 ns after each falling clock edge.
// - Control byte is code 1010, three select bits, then read/write bit.
// - Guard sampled at STOP; protected write is acknowledged, discarded, bus free immediately.
// - No acknowledge at all while a programming cycle runs.
package eeprom_pkg;

   localparam int CLK_PERIOD_NS = 10;

   localparam int GLITCH_REJECT_WIDTH_NS = 50;
   localparam int GLITCH_CYC_RAW         = GLITCH_REJECT_WIDTH_NS / CLK_PERIOD_NS;
   localparam int GLITCH_CYC             = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
   localparam int FILTER_W               = 3;

   localparam int HOLD_NS  = 300;
   localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_W   = 5;

   localparam int WRITE_CYCLE_MS  = 5;
   localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_MS * 1000000) / CLK_PERIOD_NS;

   localparam int ADDR_W     = 13;
   localparam int DATA_W     = 8;
   localparam int PAGE_W     = 5;
   localparam int FIFO_W     = ADDR_W + DATA_W;
   localparam int FIFO_DEPTH = 8;

   localparam logic [3:0] DEVICE_CODE = 4'hA;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int CODE_LSB   = 4;
   localparam int SEL_LSB    = 1;
   localparam int RW_BIT     = 0;
   localparam int ADDR_HI_W  = ADDR_W - DATA_W;

   localparam int PIN_SCL    = 0;
   localparam int PIN_SDA    = 1;
   localparam int PIN_SEL    = 2;
   localparam int PIN_GUARD  = 5;
   localparam int PIN_N      = 6;

   localparam logic [1:0] IDX_ADDR_HI = 2'h0;
   localparam logic [1:0] IDX_ADDR_LO = 2'h1;
   localparam logic [1:0] IDX_DATA    = 2'h2;

   typedef enum logic [5:0] {
      S_IDLE  = 6'h01,
      S_CTRL  = 6'h02,
      S_ACK   = 6'h04,
      S_RX    = 6'h08,
      S_TX    = 6'h10,
      S_TXACK = 6'h20
   } state_e;

endpackage : eeprom_pkg

// ===== hw/stream_if.sv
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport producer (output valid, output data, input ready);
   modport consumer (input valid, input data, output ready);
endinterface : stream_if

// ===== hw/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic   clk,
   input wire logic   reset,
   stream_if.consumer wr,
   stream_if.producer rd
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam logic [AW:0]   FULL_CNT = (AW+1)'(D);
   localparam logic [AW-1:0] LAST_IDX = AW'(D - 1);
   localparam logic [AW-1:0] ONE_IDX  = AW'(1);
   localparam logic [AW:0]   ONE_CNT  = (AW+1)'(1);

   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   wire           push = wr.valid & wr.ready;
   wire           pop  = rd.valid & rd.ready;
   wire  [AW-1:0] wp_nx = (wp_q == LAST_IDX) ? '0 : wp_q + ONE_IDX;
   wire  [AW-1:0] rp_nx = (rp_q == LAST_IDX) ? '0 : rp_q + ONE_IDX;

   assign wr.ready = (cnt_q != FULL_CNT);
   assign rd.valid = (cnt_q != '0);
   assign rd.data  = mem_q[rp_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= wr.data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_nx;
         if (pop) rp_q <= rp_nx;
         if (push && !pop) cnt_q <= cnt_q + ONE_CNT;
         else if (pop && !push) cnt_q <= cnt_q - ONE_CNT;
      end
   end

   chk_fifo_count : assert property (@(posedge clk) disable iff (reset)
      cnt_q <= FULL_CNT)
      else $error("fifo count above depth");
endmodule : word_fifo

// ===== hw/eeprom_pin_slave.sv
`timescale 1ns/1ps
module eeprom_pin_slave #(
   parameter int TWC_CYC = eeprom_pkg::WRITE_CYCLE_CYC
) (
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic                          scl_pin,
   input  wire logic                          sda_in,
   output wire logic                          sda_out,
   output wire logic                          sda_oe,
   input  wire logic                          chip_select_bit0_pin,
   input  wire logic                          chip_select_bit1_pin,
   input  wire logic                          chip_select_bit2_pin,
   input  wire logic                          write_guard_pin,
   output wire logic [eeprom_pkg::ADDR_W-1:0] rd_addr,
   input  wire logic [eeprom_pkg::DATA_W-1:0] rd_data,
   output wire logic                          arr_wr_valid,
   input  wire logic                          arr_wr_ready,
   output wire logic [eeprom_pkg::ADDR_W-1:0] arr_wr_addr,
   output wire logic [eeprom_pkg::DATA_W-1:0] arr_wr_data,
   output wire logic                          prog_busy
);
   localparam logic [eeprom_pkg::FILTER_W-1:0] GLITCH_LOAD =
      eeprom_pkg::FILTER_W'(eeprom_pkg::GLITCH_CYC);
   localparam logic [eeprom_pkg::HOLD_W-1:0] HOLD_LOAD = eeprom_pkg::HOLD_W'(eeprom_pkg::HOLD_CYC);
   localparam logic [31:0] TWC_LAST = 32'(TWC_CYC - 1);
   localparam int HOLD_CHK = eeprom_pkg::HOLD_CYC;

   // Pin synchroniser: first stage feeds only the second.
   wire  [eeprom_pkg::PIN_N-1:0] pin_raw = {write_guard_pin, chip_select_bit2_pin,
                                            chip_select_bit1_pin, chip_select_bit0_pin,
                                            sda_in, scl_pin};
   logic [eeprom_pkg::PIN_N-1:0] pin_s1_q;
   logic [eeprom_pkg::PIN_N-1:0] pin_s2_q;
   logic [1:0]                   flt;
   logic [1:0]                   flt_prev_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_filt
      logic                             f_q;
      logic [eeprom_pkg::FILTER_W-1:0] c_q;
      always_ff @(posedge clk) begin
         if (reset) begin
            f_q <= 1'b1;
            c_q <= '0;
         end else if (pin_s2_q[i] == f_q) begin
            c_q <= '0;
         end else if (c_q == GLITCH_LOAD) begin
            f_q <= pin_s2_q[i];
            c_q <= '0;
         end else begin
            c_q <= c_q + 1'b1;
         end
      end
      assign flt[i] = f_q;
   end

   always_ff @(posedge clk) begin
      if (reset) flt_prev_q <= 2'h3;
      else flt_prev_q <= flt;
   end

   wire scl_f     = flt[eeprom_pkg::PIN_SCL];
   wire sda_f     = flt[eeprom_pkg::PIN_SDA];
   wire scl_p     = flt_prev_q[eeprom_pkg::PIN_SCL];
   wire sda_p     = flt_prev_q[eeprom_pkg::PIN_SDA];
   wire scl_rise  = scl_f & ~scl_p;
   wire scl_fall  = ~scl_f & scl_p;
   // data change under high clock is a condition
   wire start_ev  = scl_f & scl_p & sda_p & ~sda_f;
   wire stop_ev   = scl_f & scl_p & ~sda_p & sda_f;
   // guard floats low via board pull-down
   wire guard     = pin_s2_q[eeprom_pkg::PIN_GUARD];
   wire [2:0] sel_pins = pin_s2_q[eeprom_pkg::PIN_SEL +: 3];

   eeprom_pkg::state_e state_q, state_d;
   logic [3:0]                    bitcnt_q, bitcnt_d;
   logic [7:0]                    shift_q, shift_d;
   logic [7:0]                    tx_q, tx_d;
   logic [1:0]                    idx_q, idx_d;
   logic                          rw_q, rw_d;
   logic                          mack_q, mack_d;
   logic                          pend_q, pend_d;
   logic                          drive_q, drive_d;
   logic [eeprom_pkg::ADDR_W-1:0] ptr_q, ptr_d;
   logic                          push_d;
   logic                          push_q;
   logic [eeprom_pkg::FIFO_W-1:0] push_data_q;
   logic                          busy_q;
   logic [31:0]                   busy_cnt_q;
   logic                          flush_q;
   logic [eeprom_pkg::HOLD_W-1:0] hold_q;
   logic                          sda_oe_q;

   // control byte decode against strapped pins
   wire sel_match = (shift_q[eeprom_pkg::CODE_LSB +: 4] == eeprom_pkg::DEVICE_CODE) &&
                    (shift_q[eeprom_pkg::SEL_LSB +: 3] == sel_pins);
   wire byte_end  = scl_fall && (bitcnt_q == eeprom_pkg::BITS_PER_BYTE);
   // guard taken at the stop that ends a write
   wire busy_set  = stop_ev && pend_q && !guard;
   wire flush_set = pend_q && ((stop_ev && guard) || start_ev);
   wire [eeprom_pkg::PAGE_W-1:0] page_nx = ptr_q[eeprom_pkg::PAGE_W-1:0] + 1'b1;

   stream_if #(.W(eeprom_pkg::FIFO_W)) fin ();
   stream_if #(.W(eeprom_pkg::FIFO_W)) fout ();

   assign fin.valid = push_q;
   assign fin.data  = push_data_q;
   assign fout.ready = (busy_q & arr_wr_ready) | flush_q;

   word_fifo #(.W(eeprom_pkg::FIFO_W), .D(eeprom_pkg::FIFO_DEPTH)) u_fifo (
      .clk   (clk),
      .reset (reset),
      .wr    (fin),
      .rd    (fout)
   );

   always_comb begin
      state_d  = state_q;
      bitcnt_d = bitcnt_q;
      shift_d  = shift_q;
      tx_d     = tx_q;
      idx_d    = idx_q;
      rw_d     = rw_q;
      mack_d   = mack_q;
      pend_d   = pend_q;
      drive_d  = drive_q;
      ptr_d    = ptr_q;
      push_d   = 1'b0;
      if (start_ev) begin
         state_d  = busy_q ? eeprom_pkg::S_IDLE : eeprom_pkg::S_CTRL;
         bitcnt_d = '0;
         idx_d    = eeprom_pkg::IDX_ADDR_HI;
         drive_d  = 1'b0;
         pend_d   = 1'b0;
      end else if (stop_ev) begin
         state_d = eeprom_pkg::S_IDLE;
         drive_d = 1'b0;
         pend_d  = 1'b0;
      end else begin
         case (state_q)
            eeprom_pkg::S_CTRL, eeprom_pkg::S_RX: begin
               if (scl_rise) begin
                  shift_d  = {shift_q[6:0], sda_f};
                  bitcnt_d = bitcnt_q + 1'b1;
               end
               if (byte_end) begin
                  bitcnt_d = '0;
                  state_d  = eeprom_pkg::S_ACK;
                  drive_d  = 1'b1;
                  if (state_q == eeprom_pkg::S_CTRL) begin
                     rw_d = shift_q[eeprom_pkg::RW_BIT];
                     if (!sel_match || busy_q) begin
                        state_d = eeprom_pkg::S_IDLE;
                        drive_d = 1'b0;
                     end
                  end else if (idx_q == eeprom_pkg::IDX_ADDR_HI) begin
                     ptr_d[eeprom_pkg::ADDR_W-1:eeprom_pkg::DATA_W] =
                        shift_q[eeprom_pkg::ADDR_HI_W-1:0];
                     idx_d = eeprom_pkg::IDX_ADDR_LO;
                  end else if (idx_q == eeprom_pkg::IDX_ADDR_LO) begin
                     ptr_d[eeprom_pkg::DATA_W-1:0] = shift_q;
                     idx_d = eeprom_pkg::IDX_DATA;
                  end else if (fin.ready) begin
                     push_d = 1'b1;
                     pend_d = 1'b1;
                     ptr_d[eeprom_pkg::PAGE_W-1:0] = page_nx;
                  end else begin
                     state_d = eeprom_pkg::S_IDLE;
                     drive_d = 1'b0;
                  end
               end
            end
            eeprom_pkg::S_ACK: begin
               if (scl_fall) begin
                  bitcnt_d = '0;
                  if (rw_q) begin
                     state_d = eeprom_pkg::S_TX;
                     tx_d    = rd_data;
                     drive_d = ~rd_data[7];
                  end else begin
                     state_d = eeprom_pkg::S_RX;
                     drive_d = 1'b0;
                  end
               end
            end
            eeprom_pkg::S_TX: begin
               if (scl_rise) bitcnt_d = bitcnt_q + 1'b1;
               if (byte_end) begin
                  state_d  = eeprom_pkg::S_TXACK;
                  bitcnt_d = '0;
                  drive_d  = 1'b0;
                  ptr_d    = ptr_q + 1'b1;
               end else if (scl_fall) begin
                  tx_d    = {tx_q[6:0], 1'b0};
                  drive_d = ~tx_q[6];
               end
            end
            eeprom_pkg::S_TXACK: begin
               if (scl_rise) mack_d = ~sda_f;
               if (scl_fall) begin
                  state_d = mack_q ? eeprom_pkg::S_TX : eeprom_pkg::S_IDLE;
                  tx_d    = rd_data;
                  drive_d = mack_q & ~rd_data[7];
               end
            end
            default: begin
               state_d = eeprom_pkg::S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q  <= eeprom_pkg::S_IDLE;
         bitcnt_q <= '0;
         shift_q  <= '0;
         tx_q     <= '0;
         idx_q    <= eeprom_pkg::IDX_ADDR_HI;
         rw_q     <= 1'b0;
         mack_q   <= 1'b0;
         pend_q   <= 1'b0;
         drive_q  <= 1'b0;
         ptr_q    <= '0;
         push_q   <= 1'b0;
      end else begin
         state_q  <= state_d;
         bitcnt_q <= bitcnt_d;
         shift_q  <= shift_d;
         tx_q     <= tx_d;
         idx_q    <= idx_d;
         rw_q     <= rw_d;
         mack_q   <= mack_d;
         pend_q   <= pend_d;
         drive_q  <= drive_d;
         ptr_q    <= ptr_d;
         push_q   <= push_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push_d) push_data_q <= {ptr_q, shift_q};
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         busy_q     <= 1'b0;
         busy_cnt_q <= '0;
      end else if (busy_set) begin
         busy_q     <= 1'b1;
         busy_cnt_q <= '0;
      end else if (busy_q) begin
         busy_cnt_q <= busy_cnt_q + 1'b1;
         if (busy_cnt_q == TWC_LAST) busy_q <= 1'b0;
      end
   end

   // protected page is dropped, bus stays free
   always_ff @(posedge clk) begin
      if (reset) flush_q <= 1'b0;
      else if (flush_set) flush_q <= 1'b1;
      else if (!fout.valid) flush_q <= 1'b0;
   end

   // drive change waits the hold time after the fall
   always_ff @(posedge clk) begin
      if (reset) begin
         hold_q   <= '0;
         sda_oe_q <= 1'b0;
      end else if (scl_fall) begin
         hold_q <= HOLD_LOAD;
      end else if (hold_q != '0) begin
         hold_q <= hold_q - 1'b1;
         if (hold_q == 5'h01 && !scl_f) sda_oe_q <= drive_q;
      end
   end

   assign sda_out      = 1'b0;
   assign sda_oe       = sda_oe_q;
   assign rd_addr      = ptr_q;
   // array writes only from an unguarded cycle
   assign arr_wr_valid = busy_q & fout.valid;
   assign arr_wr_addr  = fout.data[eeprom_pkg::FIFO_W-1:eeprom_pkg::DATA_W];
   assign arr_wr_data  = fout.data[eeprom_pkg::DATA_W-1:0];
   assign prog_busy    = busy_q;

   logic [7:0] since_fall_q;
   always_ff @(posedge clk) begin
      if (reset || scl_fall) since_fall_q <= '0;
      else if (since_fall_q != 8'hFF) since_fall_q <= since_fall_q + 1'b1;
   end

   chk_hold_after_fall : assert property (@(posedge clk) disable iff (reset)
      $changed(sda_oe_q) |-> since_fall_q >= 8'(HOLD_CHK - 1))
      else $error("data changed too soon after clock fall");
   chk_change_clock_low : assert property (@(posedge clk) disable iff (reset)
      $changed(sda_oe_q) |-> !scl_f)
      else $error("data changed while clock high");
   chk_no_ack_busy : assert property (@(posedge clk) disable iff (reset)
      busy_q |-> !sda_oe_q && state_q == eeprom_pkg::S_IDLE)
      else $error("bus driven during programming");
   chk_busy_bound : assert property (@(posedge clk) disable iff (reset)
      busy_q |-> busy_cnt_q <= TWC_LAST)
      else $error("programming cycle too long");
   chk_guard_blocks : assert property (@(posedge clk) disable iff (reset)
      $rose(busy_q) |-> !$past(guard) && $past(stop_ev))
      else $error("programming started under guard");
   chk_guard_flush : assert property (@(posedge clk) disable iff (reset)
      stop_ev && pend_q && guard |=> flush_q && !busy_q ##1 !busy_q)
      else $error("protected write not discarded");
   chk_select_match : assert property (@(posedge clk) disable iff (reset)
      state_q == eeprom_pkg::S_CTRL && byte_end && !start_ev && !stop_ev && !sel_match
      |=> state_q == eeprom_pkg::S_IDLE && !drive_q)
      else $error("unselected device answered");
   chk_filter_stable : assert property (@(posedge clk) disable iff (reset)
      $changed(flt[0]) |-> $past(pin_s2_q[0], 1) == flt[0] && $past(pin_s2_q[0], 6) == flt[0])
      else $error("clock filter passed a short pulse");
   chk_sample_on_rise : assert property (@(posedge clk) disable iff (reset)
      state_q == eeprom_pkg::S_RX && !scl_rise && !start_ev && !stop_ev |=> $stable(shift_q))
      else $error("data shifted without a clock rise");

   cov_start : cover property (@(posedge clk) disable iff (reset) start_ev);
   cov_write_commit : cover property (@(posedge clk) disable iff (reset) $rose(busy_q));
   cov_read_byte : cover property (@(posedge clk) disable iff (reset)
      state_q == eeprom_pkg::S_TX && byte_end);
   cov_guard_flush : cover property (@(posedge clk) disable iff (reset) $rose(flush_q));
endmodule : eeprom_pin_slave

// ===== bench/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model #(
   parameter int Q = 25
) (
   input  wire logic clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask : w
   task automatic bit_xfer(input logic drv, output logic smp);
      w(Q);
      sda_low = drv;
      w(Q);
      scl = 1'b1;
      w(Q);
      smp = sda_line;
      w(Q);
      scl = 1'b0;
   endtask : bit_xfer
   task automatic start();
      w(Q);
      sda_low = 1'b0;
      w(Q);
      scl = 1'b1;
      w(Q);
      sda_low = 1'b1;
      w(Q);
      scl = 1'b0;
   endtask : start
   task automatic stop();
      w(Q);
      sda_low = 1'b1;
      w(Q);
      scl = 1'b1;
      w(Q);
      sda_low = 1'b0;
      w(3 * Q);
   endtask : stop
   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(~b[i], s);
      end
      bit_xfer(1'b0, s);
      ack = ~s;
   endtask : write_byte
   task automatic read_byte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b0, s);
         b[i] = s;
      end
      bit_xfer(ack, s);
   endtask : read_byte
   task automatic scl_glitch();
      w(Q);
      scl = 1'b1;
      w(3);
      scl = 1'b0;
   endtask : scl_glitch
endmodule : i2c_master_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
   $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module tb_top;
   localparam int TWC = 2000;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        scl, m_low, sda_oe, sda_out, guard, arr_wr_valid, arr_wr_ready, prog_busy;
   logic [2:0]  cs_pins;
   logic [12:0] rd_addr, arr_wr_addr;
   logic [7:0]  arr_wr_data, mem [0:8191];
   logic [20:0] exp_q [$];
   logic        oe_d = 1'b0;
   int          fail_count, check_count, fall_cnt, busy_len, hi_cnt;
   wire         sda_line = ~(m_low | sda_oe);
   wire  [7:0]  rd_data = mem[rd_addr];
   always #5 clk = ~clk;
   eeprom_pin_slave #(.TWC_CYC(TWC)) eeprom_pin_slave_i (
      .clk(clk), .reset(reset), .scl_pin(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .chip_select_bit0_pin(cs_pins[0]), .chip_select_bit1_pin(cs_pins[1]),
      .chip_select_bit2_pin(cs_pins[2]), .write_guard_pin(guard), .rd_addr(rd_addr),
      .rd_data(rd_data), .arr_wr_valid(arr_wr_valid), .arr_wr_ready(arr_wr_ready),
      .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data), .prog_busy(prog_busy));
   i2c_master_model i2c_master_model_i (.clk(clk), .sda_line(sda_line), .scl(scl),
      .sda_low(m_low));
   always @(posedge clk) begin
      // A clock spike shorter than the glitch width does not restart the hold count.
      hi_cnt   <= scl ? hi_cnt + 1 : 0;
      fall_cnt <= (scl && hi_cnt >= eeprom_pkg::GLITCH_CYC) ? 0 : fall_cnt + 1;
      oe_d <= sda_oe;
      busy_len <= (prog_busy === 1'b1) ? busy_len + 1 : 0;
      if (!reset && sda_oe !== oe_d) begin
         `CHECK("hold", 1'b1, fall_cnt >= eeprom_pkg::HOLD_CYC && scl === 1'b0)
         `CHECK("sda_out", 1'b0, sda_out)
      end
      if (prog_busy !== 1'b1 && busy_len != 0) begin
         `CHECK("busy_len", 1'b1, busy_len <= TWC)
      end
   end
   function automatic logic [7:0] ctrl(input logic [2:0] sel, input logic rw);
      return {eeprom_pkg::DEVICE_CODE, sel, rw};
   endfunction : ctrl
   task automatic tx(input logic [7:0] b, input logic exp);
      logic a;
      i2c_master_model_i.write_byte(b, a);
      `CHECK("ack", exp, a)
   endtask : tx
   task automatic hdr(input logic [12:0] a, input logic g);
      i2c_master_model_i.start();
      tx(ctrl(3'h5, 1'b0), 1'b1);
      tx({3'h0, a[12:8]}, 1'b1);
      if (g) i2c_master_model_i.scl_glitch();
      tx(a[7:0], 1'b1);
   endtask : hdr
   task automatic rd_check(input logic [12:0] a, input int n, input logic g);
      logic [7:0]  b;
      logic [12:0] p;
      hdr(a, g);
      i2c_master_model_i.start();
      tx(ctrl(3'h5, 1'b1), 1'b1);
      for (int i = 0; i < n; i++) begin
         p = a + i[12:0];
         i2c_master_model_i.read_byte(i < n - 1, b);
         `CHECK("rd_byte", mem[p], b)
      end
      i2c_master_model_i.stop();
   endtask : rd_check
   task automatic drain(input int stall);
      logic [20:0] e;
      repeat (stall) @(negedge clk);
      while (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         @(negedge clk);
         `CHECK("wr_valid", 1'b1, arr_wr_valid)
         `CHECK("wr_addr", e[20:8], arr_wr_addr)
         `CHECK("wr_data", e[7:0], arr_wr_data)
         mem[e[20:8]] = e[7:0];
         arr_wr_ready = 1'b1;
         @(negedge clk);
         arr_wr_ready = 1'b0;
      end
      @(negedge clk);
      `CHECK("wr_empty", 1'b0, arr_wr_valid)
   endtask : drain
   task automatic wait_idle();
      int n;
      n = 0;
      while (prog_busy !== 1'b0 && n < TWC + 50) begin
         @(negedge clk);
         n++;
      end
      `CHECK("busy_end", 1'b0, prog_busy)
   endtask : wait_idle
   task automatic t_select();
      for (int k = 0; k < 8; k++) begin
         i2c_master_model_i.start();
         tx(ctrl(k[2:0], 1'b0), k == 5);
         i2c_master_model_i.stop();
      end
      i2c_master_model_i.start();
      tx({4'hB, 3'h5, 1'b0}, 1'b0);
      i2c_master_model_i.stop();
   endtask : t_select
   task automatic t_write();
      hdr(13'h1FFF, 1'b0);
      tx(8'h3C, 1'b1);
      tx(8'hE1, 1'b1);
      exp_q.push_back({13'h1FFF, 8'h3C});
      exp_q.push_back({13'h1FE0, 8'hE1});
      i2c_master_model_i.stop();
      `CHECK("busy", 1'b1, prog_busy)
      drain(20);
      i2c_master_model_i.start();
      tx(ctrl(3'h5, 1'b0), 1'b0);
      i2c_master_model_i.stop();
      wait_idle();
      rd_check(13'h1FFF, 2, 1'b0);
   endtask : t_write
   task automatic t_fill();
      hdr(13'h0100, 1'b0);
      for (int i = 0; i < 9; i++) begin
         tx(8'h80 + i[7:0], i < 8);
         if (i < 8) exp_q.push_back({13'h0100 + i[12:0], 8'h80 + i[7:0]});
      end
      i2c_master_model_i.stop();
      drain(40);
      wait_idle();
   endtask : t_fill
   task automatic t_guard();
      guard = 1'b1;
      hdr(13'h0040, 1'b0);
      tx(8'h99, 1'b1);
      i2c_master_model_i.stop();
      repeat (5) @(negedge clk);
      `CHECK("g_busy", 1'b0, prog_busy)
      `CHECK("g_valid", 1'b0, arr_wr_valid)
      rd_check(13'h0040, 1, 1'b1);
      guard = 1'b0;
   endtask : t_guard
   task automatic t_restart();
      logic [7:0] b;
      hdr(13'h0060, 1'b0);
      tx(8'h77, 1'b1);
      i2c_master_model_i.start();
      tx(ctrl(3'h5, 1'b1), 1'b1);
      i2c_master_model_i.read_byte(1'b0, b);
      `CHECK("cur_byte", mem[13'h0061], b)
      i2c_master_model_i.stop();
      `CHECK("r_busy", 1'b0, prog_busy)
      hdr(13'h0070, 1'b0);
      tx(8'h11, 1'b1);
      exp_q.push_back({13'h0070, 8'h11});
      i2c_master_model_i.stop();
      drain(10);
      wait_idle();
   endtask : t_restart
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      results();
   end
   initial begin
      arr_wr_ready = 1'b0;
      guard = 1'b0;
      cs_pins = 3'h5;
      for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'h5A;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      repeat (20) @(negedge clk);
      t_select();
      t_write();
      t_fill();
      t_guard();
      t_restart();
      results();
   end
endmodule : tb_top
